/* File: design/scr_pkg.sv */
// shared constants and types of the scan command and format registers
package scr_pkg;
    // register offsets
    localparam logic [7:0] SCR_OFS_CMD = 8'h07;
    localparam logic [7:0] SCR_OFS_MCLK = 8'h08;
    localparam logic [7:0] SCR_OFS_FMT = 8'h09;
    localparam logic [7:0] SCR_OFS_FEED_MSB = 8'h48;
    localparam logic [7:0] SCR_OFS_FEED_LSB = 8'h49;
    localparam logic [7:0] SCR_OFS_STATUS = 8'h4a;
    // reset values
    localparam logic [7:0] SCR_RST_CMD = 8'h00;
    localparam logic [7:0] SCR_RST_MCLK = 8'h00;
    localparam logic [7:0] SCR_RST_FMT = 8'h00;
    localparam logic [15:0] SCR_RST_FEED = 16'h0010;
    // command register fields
    localparam int SCR_CMD_LSB = 0;
    localparam int SCR_STANDBY_BIT = 2;
    localparam int SCR_RESET_BIT = 3;
    // divider register field
    localparam int SCR_MCLK_LSB = 0;
    localparam int SCR_MCLK_W = 6;
    // format register fields
    localparam int SCR_DPI_LSB = 0;
    localparam int SCR_PACK_LSB = 3;
    localparam int SCR_MODE_BIT = 5;
    // ratio in half crystal cycles is code plus this
    localparam logic [6:0] SCR_MCLK_HALF_BASE = 7'h02;
    localparam logic [6:0] SCR_HALF_STEP = 7'h02;
    // converter clock is master clock over this plus one
    localparam logic [2:0] SCR_ADC_LAST = 3'h7;
    // motor full-step phase patterns, bit order a, b, a_n, b_n
    localparam logic [3:0] SCR_PHASE_0 = 4'h9;
    localparam logic [3:0] SCR_PHASE_1 = 4'hc;
    localparam logic [3:0] SCR_PHASE_2 = 4'h6;
    localparam logic [3:0] SCR_PHASE_3 = 4'h3;

    typedef enum logic [1:0] {
        SCR_CMD_IDLE = 2'h0,
        SCR_CMD_FWD = 2'h1,
        SCR_CMD_REV = 2'h2,
        SCR_CMD_SCAN = 2'h3
    } scr_cmd_e;

    typedef enum logic [1:0] {
        SCR_PACK_1 = 2'h0,
        SCR_PACK_2 = 2'h1,
        SCR_PACK_4 = 2'h2,
        SCR_PACK_8 = 2'h3
    } scr_pack_e;

    typedef enum {
        SCR_SC_IDLE,
        SCR_SC_CLEAR,
        SCR_SC_RUN,
        SCR_SC_FINISH
    } scr_scan_e;
endpackage : scr_pkg

/* File: design/scr_pixel_fmt.sv */
// pixel packer and two-byte word formatter for the host byte stream
`timescale 1ns/1ps
`default_nettype none
module scr_pixel_fmt
    import scr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // control
    input wire logic hold,
    input wire logic mode_word,
    input wire logic raw_sel,
    input wire logic [1:0] pack_depth,
    // pixel input
    input wire logic pix_valid,
    input wire logic [11:0] pix_data,
    output logic pix_ready,
    // byte output
    output logic byte_valid,
    output logic [7:0] byte_data
);
    logic [7:0] acc;
    logic [3:0] bits;
    logic pend;
    logic [7:0] pend_byte;
    logic next_pix_ready;
    logic next_byte_valid;
    logic [7:0] next_byte_data;
    logic [7:0] next_acc;
    logic [3:0] next_bits;
    logic next_pend;
    logic [7:0] next_pend_byte;
    logic [3:0] width;
    logic [7:0] top;
    logic [7:0] shifted;

    always_comb begin
        width = 4'h1;
        top = 8'h00;
        unique case (scr_pack_e'(pack_depth))
            SCR_PACK_1: begin
                width = 4'h1;
                top = {7'h00, pix_data[7]};
            end
            SCR_PACK_2: begin
                width = 4'h2;
                top = {6'h00, pix_data[7:6]};
            end
            SCR_PACK_4: begin
                width = 4'h4;
                top = {4'h0, pix_data[7:4]};
            end
            SCR_PACK_8: begin
                width = 4'h8;
                top = pix_data[7:0];
            end
        endcase
        shifted = (acc << width) | top;
        next_acc = acc;
        next_bits = bits;
        next_pend = pend;
        next_pend_byte = pend_byte;
        next_byte_valid = 1'b0;
        next_byte_data = byte_data;
        if (hold) begin
            next_acc = 8'h00;
            next_bits = 4'h0;
            next_pend = 1'b0;
        end else if (pend) begin
            // second byte of a word
            next_byte_valid = 1'b1;
            next_byte_data = pend_byte;
            next_pend = 1'b0;
        end else if (pix_valid && pix_ready) begin
            if (mode_word && raw_sel) begin
                next_byte_valid = 1'b1;
                next_byte_data = {4'h0, pix_data[11:8]};
                next_pend = 1'b1;
                next_pend_byte = pix_data[7:0];
            end else if (mode_word) begin
                next_byte_valid = 1'b1;
                next_byte_data = {4'h0, pix_data[9:6]};
                next_pend = 1'b1;
                next_pend_byte = {pix_data[5:0], 2'b00};
            end else begin
                if (bits + width >= 4'h8) begin
                    next_byte_valid = 1'b1;
                    next_byte_data = shifted;
                    next_acc = 8'h00;
                    next_bits = 4'h0;
                end else begin
                    next_acc = shifted;
                    next_bits = bits + width;
                end
            end
        end
        next_pix_ready = !hold && !next_pend;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            acc <= 8'h00;
            bits <= 4'h0;
            pend <= 1'b0;
            pend_byte <= 8'h00;
            pix_ready <= 1'b0;
            byte_valid <= 1'b0;
            byte_data <= 8'h00;
        end else begin
            acc <= next_acc;
            bits <= next_bits;
            pend <= next_pend;
            pend_byte <= next_pend_byte;
            pix_ready <= next_pix_ready;
            byte_valid <= next_byte_valid;
            byte_data <= next_byte_data;
        end
    end
endmodule : scr_pixel_fmt
`default_nettype wire

/* File: design/scr_regs.sv */
// scan command, clock divider and output format register bank
// Functional notes
// - idle zeroes motor phases, finishes line
// - fast forward steps at feed rate
// - fast reverse steps at feed rate
// - start scan clears pointers, then scans
// - standby freezes clocks, powers analog down
// - reset bit holds device in reset
// - master clock is crystal over code/2+1
// - converter clock is master clock over eight
// - output resolution uses divider field
// - processed mode packs 1/2/4/8 bits
// - mode zero uses full processing chain
// - mode one sends 10-bit in two bytes
// - raw 12-bit when divider zero (the code also requires raw_coef_zero high)
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module scr_regs
    import scr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // pixel pipeline handshake
    input wire logic line_done,
    input wire logic raw_coef_zero,
    input wire logic pix_valid,
    input wire logic [11:0] pix_data,
    output logic pix_ready,
    output logic byte_valid,
    output logic [7:0] byte_data,
    // clocks and power
    output logic mclk_en,
    output logic adc_en,
    output logic analog_power_down,
    output logic core_reset,
    // motor
    output logic [3:0] motor_phase,
    // scan control
    output logic clear_pointers,
    output logic scan_active,
    output logic [2:0] dpi_divider,
    output logic full_process,
    output logic bypass_gamma
);
    // registers
    logic [7:0] cmd_reg;
    logic [7:0] mclk_reg;
    logic [7:0] fmt_reg;
    logic [15:0] feed_reg;
    logic [7:0] next_cmd_reg;
    logic [7:0] next_mclk_reg;
    logic [7:0] next_fmt_reg;
    logic [15:0] next_feed_reg;
    logic [7:0] next_reg_rdata;
    logic start_req;
    logic next_start_req;

    wire logic standby = cmd_reg[SCR_STANDBY_BIT];
    wire logic soft_rst = cmd_reg[SCR_RESET_BIT];
    wire logic [1:0] cmd_field = cmd_reg[SCR_CMD_LSB +: 2];
    wire logic [2:0] dpi_field = fmt_reg[SCR_DPI_LSB +: 3];
    wire logic [1:0] pack_field = fmt_reg[SCR_PACK_LSB +: 2];
    wire logic mode_field = fmt_reg[SCR_MODE_BIT];
    scr_scan_e scan_state;
    logic [1:0] motor_cmd;
    wire logic [1:0] scan_code = scan_state == SCR_SC_IDLE ? 2'h0 :
        (scan_state == SCR_SC_CLEAR ? 2'h1 :
        (scan_state == SCR_SC_RUN ? 2'h2 : 2'h3));

    always_comb begin
        next_cmd_reg = cmd_reg;
        next_mclk_reg = mclk_reg;
        next_fmt_reg = fmt_reg;
        next_feed_reg = feed_reg;
        next_start_req = 1'b0;
        next_reg_rdata = 8'h00;
        if (reg_wr) begin
            unique case (reg_addr)
                SCR_OFS_CMD: begin
                    next_cmd_reg = reg_wdata;
                    next_start_req = reg_wdata[SCR_CMD_LSB +: 2] ==
                        SCR_CMD_SCAN;
                end
                SCR_OFS_MCLK: next_mclk_reg = {2'b00,
                    reg_wdata[SCR_MCLK_LSB +: SCR_MCLK_W]};
                SCR_OFS_FMT: next_fmt_reg = {2'b00, reg_wdata[5:0]};
                SCR_OFS_FEED_MSB: next_feed_reg[15:8] = reg_wdata;
                SCR_OFS_FEED_LSB: next_feed_reg[7:0] = reg_wdata;
                default: begin
                end
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                SCR_OFS_CMD: next_reg_rdata = cmd_reg;
                SCR_OFS_MCLK: next_reg_rdata = mclk_reg;
                SCR_OFS_FMT: next_reg_rdata = fmt_reg;
                SCR_OFS_FEED_MSB: next_reg_rdata = feed_reg[15:8];
                SCR_OFS_FEED_LSB: next_reg_rdata = feed_reg[7:0];
                SCR_OFS_STATUS: next_reg_rdata = {2'b00, motor_cmd,
                    scan_code, analog_power_down, core_reset};
                default: next_reg_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_reg <= SCR_RST_CMD;
            mclk_reg <= SCR_RST_MCLK;
            fmt_reg <= SCR_RST_FMT;
            feed_reg <= SCR_RST_FEED;
            start_req <= 1'b0;
            reg_rdata <= 8'h00;
        end else begin
            cmd_reg <= next_cmd_reg;
            mclk_reg <= next_mclk_reg;
            fmt_reg <= next_fmt_reg;
            feed_reg <= next_feed_reg;
            start_req <= next_start_req;
            reg_rdata <= next_reg_rdata;
        end
    end

    // clock enables
    logic [6:0] half_acc;
    logic [6:0] half_period;
    logic [2:0] adc_cnt;
    logic [6:0] next_half_acc;
    logic [6:0] next_half_period;
    logic [2:0] next_adc_cnt;
    logic next_mclk_en;
    logic next_adc_en;
    logic [6:0] acc_sum;
    logic freeze;

    always_comb begin
        freeze = standby || soft_rst;
        acc_sum = half_acc + SCR_HALF_STEP;
        next_half_acc = half_acc;
        next_half_period = half_period;
        next_adc_cnt = adc_cnt;
        next_mclk_en = 1'b0;
        next_adc_en = 1'b0;
        if (soft_rst) begin
            next_half_acc = 7'h00;
            next_adc_cnt = 3'h0;
            next_half_period = mclk_reg[6:0] + SCR_MCLK_HALF_BASE;
        end else if (!freeze) begin
            if (acc_sum >= half_period) begin
                next_mclk_en = 1'b1;
                next_half_acc = acc_sum - half_period;
                // new ratio at a pulse boundary
                next_half_period = mclk_reg[6:0] + SCR_MCLK_HALF_BASE;
                next_adc_cnt = adc_cnt + 3'h1;
                next_adc_en = adc_cnt == SCR_ADC_LAST;
            end else begin
                next_half_acc = acc_sum;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            half_acc <= 7'h00;
            half_period <= SCR_MCLK_HALF_BASE;
            adc_cnt <= 3'h0;
            mclk_en <= 1'b0;
            adc_en <= 1'b0;
        end else begin
            half_acc <= next_half_acc;
            half_period <= next_half_period;
            adc_cnt <= next_adc_cnt;
            mclk_en <= next_mclk_en;
            adc_en <= next_adc_en;
        end
    end

    // motor feed
    logic [15:0] step_cnt;
    logic [1:0] phase_idx;
    logic [1:0] next_motor_cmd;
    logic [15:0] next_step_cnt;
    logic [1:0] next_phase_idx;
    logic [3:0] next_motor_phase;
    logic step_due;
    logic moving;

    always_comb begin
        moving = motor_cmd == SCR_CMD_FWD || motor_cmd == SCR_CMD_REV;
        step_due = mclk_en && (step_cnt + 16'h0001 >= feed_reg);
        next_motor_cmd = motor_cmd;
        next_step_cnt = step_cnt;
        next_phase_idx = phase_idx;
        if (soft_rst) begin
            next_motor_cmd = SCR_CMD_IDLE;
            next_step_cnt = 16'h0000;
        end else if (!moving || step_due) begin
            next_motor_cmd = cmd_field;
            next_step_cnt = 16'h0000;
            if (step_due && motor_cmd == SCR_CMD_FWD) begin
                next_phase_idx = phase_idx + 2'h1;
            end else if (step_due && motor_cmd == SCR_CMD_REV) begin
                next_phase_idx = phase_idx - 2'h1;
            end
        end else if (mclk_en) begin
            next_step_cnt = step_cnt + 16'h0001;
        end
        next_motor_phase = 4'h0;
        if (!soft_rst && (next_motor_cmd == SCR_CMD_FWD ||
                next_motor_cmd == SCR_CMD_REV)) begin
            unique case (next_phase_idx)
                2'h0: next_motor_phase = SCR_PHASE_0;
                2'h1: next_motor_phase = SCR_PHASE_1;
                2'h2: next_motor_phase = SCR_PHASE_2;
                2'h3: next_motor_phase = SCR_PHASE_3;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            motor_cmd <= SCR_CMD_IDLE;
            step_cnt <= 16'h0000;
            phase_idx <= 2'h0;
            motor_phase <= 4'h0;
        end else begin
            motor_cmd <= next_motor_cmd;
            step_cnt <= next_step_cnt;
            phase_idx <= next_phase_idx;
            motor_phase <= next_motor_phase;
        end
    end

    // scan sequencing and pipeline steering
    scr_scan_e next_scan_state;
    logic next_clear_pointers;
    logic next_scan_active;
    logic next_analog_power_down;
    logic next_core_reset;
    logic next_full_process;
    logic next_bypass_gamma;
    logic fmt_hold;

    always_comb begin
        next_scan_state = scan_state;
        if (soft_rst) begin
            next_scan_state = SCR_SC_IDLE;
        end else begin
            unique case (scan_state)
                SCR_SC_IDLE:
                    if (start_req) begin
                        next_scan_state = SCR_SC_CLEAR;
                    end
                SCR_SC_CLEAR: next_scan_state = SCR_SC_RUN;
                SCR_SC_RUN:
                    if (cmd_field != SCR_CMD_SCAN) begin
                        next_scan_state = SCR_SC_FINISH;
                    end
                SCR_SC_FINISH:
                    if (line_done) begin
                        next_scan_state = SCR_SC_IDLE;
                    end
            endcase
        end
        next_clear_pointers = next_scan_state == SCR_SC_CLEAR;
        next_scan_active = next_scan_state == SCR_SC_RUN ||
            next_scan_state == SCR_SC_FINISH;
        next_analog_power_down = standby;
        next_core_reset = soft_rst;
        next_full_process = !mode_field;
        next_bypass_gamma = mode_field;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            scan_state <= SCR_SC_IDLE;
            clear_pointers <= 1'b0;
            scan_active <= 1'b0;
            analog_power_down <= 1'b0;
            core_reset <= 1'b0;
            dpi_divider <= 3'h0;
            full_process <= 1'b1;
            bypass_gamma <= 1'b0;
        end else begin
            scan_state <= next_scan_state;
            clear_pointers <= next_clear_pointers;
            scan_active <= next_scan_active;
            analog_power_down <= next_analog_power_down;
            core_reset <= next_core_reset;
            dpi_divider <= dpi_field;
            full_process <= next_full_process;
            bypass_gamma <= next_bypass_gamma;
        end
    end

    assign fmt_hold = soft_rst || standby || clear_pointers;

    scr_pixel_fmt u_fmt (
        .clk(clk),
        .rst_b(rst_b),
        .hold(fmt_hold),
        .mode_word(mode_field),
        // raw path needs divider and coefficients zero
        .raw_sel(dpi_field == 3'h0 && raw_coef_zero),
        .pack_depth(pack_field),
        .pix_valid(pix_valid),
        .pix_data(pix_data),
        .pix_ready(pix_ready),
        .byte_valid(byte_valid),
        .byte_data(byte_data)
    );
endmodule : scr_regs
`default_nettype wire

/* File: dv/scr_regs_assertions.sv */
// port checks of the scan command and format register bank
`timescale 1ns/1ps
`default_nettype none
module scr_regs_chk
    import scr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // pixels
    input wire logic raw_coef_zero,
    input wire logic pix_valid,
    input wire logic [11:0] pix_data,
    input wire logic pix_ready,
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    // clocks, motor and scan
    input wire logic mclk_en,
    input wire logic adc_en,
    input wire logic analog_power_down,
    input wire logic core_reset,
    input wire logic [3:0] motor_phase,
    input wire logic clear_pointers,
    input wire logic scan_active,
    input wire logic [2:0] dpi_divider,
    input wire logic bypass_gamma
);
    logic [5:0] gap;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // cycles since the last master clock pulse while running
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            gap <= 6'h00;
        end else if (mclk_en || core_reset || analog_power_down) begin
            gap <= 6'h00;
        end else begin
            gap <= gap + 6'h01;
        end
    end
    sequence s_cmd_wr;
        reg_wr && reg_addr == SCR_OFS_CMD;
    endsequence
    sequence s_take;
        pix_valid && pix_ready && bypass_gamma;
    endsequence
    sequence s_raw;
        raw_coef_zero && dpi_divider == 3'h0;
    endsequence
    property p_rd_idle;
        !$past(reg_rd) |-> reg_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("stale read data");
    property p_cmd_bits;
        s_cmd_wr |=> ##1 analog_power_down == $past(reg_wdata[2], 2)
            && core_reset == $past(reg_wdata[3], 2);
    endproperty
    a_cmd_bits: assert property (p_cmd_bits)
        else $error("standby or reset bit not applied");
    property p_frozen;
        (analog_power_down || core_reset) && $past(analog_power_down
            || core_reset) |-> !mclk_en && !adc_en;
    endproperty
    a_frozen: assert property (p_frozen) else $error("clock not frozen");
    property p_reset_hold;
        core_reset && $past(core_reset) |-> motor_phase == 4'h0
            && !scan_active;
    endproperty
    a_reset_hold: assert property (p_reset_hold)
        else $error("state runs in reset");
    property p_adc;
        adc_en |-> mclk_en;
    endproperty
    a_adc: assert property (p_adc) else $error("adc pulse off mclk");
    property p_gap;
        gap <= 6'h21;
    endproperty
    a_gap: assert property (p_gap) else $error("mclk gap too long");
    property p_scan;
        $rose(scan_active) |-> $past(clear_pointers);
    endproperty
    a_scan: assert property (p_scan) else $error("scan without clear");
    property p_step;
        $changed(motor_phase) && motor_phase != 4'h0 && $past(motor_phase)
            != 4'h0 |-> {$past(motor_phase), motor_phase} inside {8'h9c,
            8'hc6, 8'h63, 8'h39, 8'hc9, 8'h6c, 8'h36, 8'h93};
    endproperty
    a_step: assert property (p_step) else $error("bad motor step");
    property p_word;
        s_take and !(raw_coef_zero && dpi_divider == 3'h0) |=>
            byte_valid && byte_data[3:0] == $past(pix_data[9:6]) ##1
            byte_valid && byte_data[7:2] == $past(pix_data[5:0], 2);
    endproperty
    a_word: assert property (p_word) else $error("bad 10-bit word");
    property p_raw;
        s_take and s_raw |=> byte_valid && byte_data[3:0] ==
            $past(pix_data[11:8]) ##1 byte_valid && byte_data ==
            $past(pix_data[7:0], 2);
    endproperty
    a_raw: assert property (p_raw) else $error("bad raw word");
endmodule : scr_regs_chk
bind scr_regs scr_regs_chk u_chk (.clk(clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .raw_coef_zero(raw_coef_zero),
    .pix_valid(pix_valid), .pix_data(pix_data), .pix_ready(pix_ready),
    .byte_valid(byte_valid), .byte_data(byte_data), .mclk_en(mclk_en),
    .adc_en(adc_en), .analog_power_down(analog_power_down),
    .core_reset(core_reset), .motor_phase(motor_phase),
    .clear_pointers(clear_pointers), .scan_active(scan_active),
    .dpi_divider(dpi_divider), .bypass_gamma(bypass_gamma));
`default_nettype wire

/* File: dv/scr_regs_bench.sv */
// self-checking bench of the scan command and format register bank
`timescale 1ns/1ps
`default_nettype none
module scr_regs_bench
    import scr_pkg::*;
;
    typedef struct {logic w; logic [7:0] a; logic [7:0] d;} scr_row_s;
    logic clk, rst_b, reg_wr, reg_rd, line_done, raw_coef_zero, pix_valid;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, byte_data;
    logic [11:0] pix_data;
    logic pix_ready, byte_valid, mclk_en, adc_en, analog_power_down;
    logic core_reset, clear_pointers, scan_active, full_process;
    logic bypass_gamma;
    logic [3:0] motor_phase;
    logic [2:0] dpi_divider;
    logic [7:0] bq[$];
    logic [3:0] pat[4] = '{4'h9, 4'hc, 4'h6, 4'h3};
    int fail_count = 0;
    int check_count = 0;
    int m, ad, n, k, w;
    // write rows compare nothing, read rows expect d
    scr_row_s rows[17] = '{'{0, 8'h07, 8'h00}, '{0, 8'h08, 8'h00},
        '{0, 8'h09, 8'h00}, '{0, 8'h48, 8'h00}, '{0, 8'h49, 8'h10},
        '{0, 8'h0a, 8'h00}, '{1, 8'h08, 8'hff}, '{0, 8'h08, 8'h3f},
        '{1, 8'h09, 8'hff}, '{0, 8'h09, 8'h3f}, '{1, 8'h0a, 8'h55},
        '{0, 8'h0a, 8'h00}, '{1, 8'h48, 8'h12}, '{1, 8'h49, 8'h34},
        '{0, 8'h48, 8'h12}, '{0, 8'h49, 8'h34}, '{1, 8'h09, 8'h00}};
    scr_regs uut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .line_done(line_done),
        .raw_coef_zero(raw_coef_zero), .pix_valid(pix_valid),
        .pix_data(pix_data), .pix_ready(pix_ready),
        .byte_valid(byte_valid), .byte_data(byte_data), .mclk_en(mclk_en),
        .adc_en(adc_en), .analog_power_down(analog_power_down),
        .core_reset(core_reset), .motor_phase(motor_phase),
        .clear_pointers(clear_pointers), .scan_active(scan_active),
        .dpi_divider(dpi_divider), .full_process(full_process),
        .bypass_gamma(bypass_gamma));
    always #10 clk = ~clk;
    always @(posedge clk) begin
        if (byte_valid === 1'b1) begin
            bq.push_back(byte_data);
        end
    end
    task automatic stop_test();
        if (fail_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk8
    task automatic chk_rng(input int got, input int lo, input int hi);
        check_count++;
        if (got < lo || got > hi) begin
            fail_count++;
            $display("ERROR %0t count %0d not in %0d..%0d", $time, got, lo,
                hi);
        end
    endtask : chk_rng
    task automatic tmo(input int cnt, input int lim);
        if (cnt >= lim) begin
            fail_count++;
            $display("ERROR %0t wait ran out", $time);
            stop_test();
        end
    endtask : tmo
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk8(reg_rdata, e);
    endtask : rd
    task automatic cnt_clk(input int cyc);
        m = 0;
        ad = 0;
        repeat (cyc) begin
            @(negedge clk);
            m += int'(mclk_en === 1'b1);
            ad += int'(adc_en === 1'b1);
        end
    endtask : cnt_clk
    task automatic px(input logic [11:0] d);
        @(posedge clk);
        pix_valid <= 1'b1;
        pix_data <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pix_ready !== 1'b1 && n < 50);
        pix_valid <= 1'b0;
        tmo(n, 50);
    endtask : px
    // follow four steps and compare each with its neighbour in the cycle
    task automatic steps(input int dir);
        for (int s = 0; s < 4; s++) begin
            for (n = 0; n < 100 && motor_phase === pat[k]; n++) @(negedge clk);
            tmo(n, 100);
            k = (k + dir) & 3;
            chk8({4'h0, motor_phase}, {4'h0, pat[k]});
        end
    endtask : steps
    initial begin
        {clk, rst_b, reg_wr, reg_rd, line_done, raw_coef_zero} = '0;
        {pix_valid, pix_data, reg_addr, reg_wdata} = '0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].w) wr(rows[i].a, rows[i].d);
            else rd(rows[i].a, rows[i].d);
        end
        foreach (pat[i]) begin
            wr(8'h08, {2'b00, 6'(i == 3 ? 63 : i * 3)});
            cnt_clk(80);
            w = (i == 3 ? 65 : i * 3 + 2) * 20;
            cnt_clk(w);
            chk_rng(m, 39, 41);
            chk_rng(ad, 4, 6);
        end
        wr(8'h08, 8'h00);
        for (int b = 2; b < 4; b++) begin
            wr(8'h07, 8'h01 << b);
            cnt_clk(40);
            chk_rng(m, 0, 1);
            chk8({analog_power_down, core_reset}, 8'h02 >> (b - 2));
            wr(8'h07, 8'h00);
        end
        wr(8'h48, 8'h00);
        wr(8'h49, 8'h04);
        wr(8'h07, 8'h01);
        for (n = 0; n < 100 && motor_phase === 4'h0; n++) @(negedge clk);
        tmo(n, 100);
        for (k = 0; k < 3 && pat[k] !== motor_phase; k++);
        steps(1);
        wr(8'h07, 8'h02);
        for (n = 0; n < 20 && motor_phase !== pat[(k + 3) & 3]; n++) begin
            @(negedge clk);
        end
        tmo(n, 20);
        k = (k + 3) & 3;
        steps(3);
        wr(8'h07, 8'h00);
        cnt_clk(30);
        chk8({4'h0, motor_phase}, 8'h00);
        wr(8'h07, 8'h03);
        for (n = 0; n < 10 && clear_pointers !== 1'b1; n++) @(negedge clk);
        tmo(n, 10);
        @(negedge clk);
        chk8({7'h00, scan_active}, 8'h01);
        wr(8'h07, 8'h00);
        cnt_clk(20);
        chk8({7'h00, scan_active}, 8'h01);
        @(posedge clk);
        line_done <= 1'b1;
        @(posedge clk);
        line_done <= 1'b0;
        for (n = 0; n < 10 && scan_active !== 1'b0; n++) @(negedge clk);
        tmo(n, 10);
        wr(8'h09, 8'h21);
        bq.delete();
        px(12'h2b5);
        cnt_clk(5);
        chk8({4'h0, bq[0][3:0]}, 8'h0a);
        chk8({bq[1][7:2], 2'b00}, 8'hd4);
        chk8({5'h00, dpi_divider}, 8'h01);
        chk8({6'h00, full_process, bypass_gamma}, 8'h01);
        wr(8'h09, 8'h20);
        raw_coef_zero <= 1'b1;
        bq.delete();
        px(12'ha5c);
        raw_coef_zero <= 1'b0;
        cnt_clk(5);
        chk8({4'h0, bq[0][3:0]}, 8'h0a);
        chk8(bq[1], 8'h5c);
        for (int c = 0; c < 4; c++) begin
            wr(8'h09, 8'(c << 3));
            bq.delete();
            w = 1 << c;
            for (int i = 0; i < 8 / w; i++) begin
                px({4'h0, (8'hb4 << (w * i)) & (8'hff << (8 - w))});
            end
            cnt_clk(5);
            chk8(8'(bq.size()), 8'h01);
            chk8(bq[0], 8'hb4);
        end
        stop_test();
    end
endmodule : scr_regs_bench
`default_nettype wire
